// [core/cfm_clock_fault_monitor.v]
`timescale 1ns/10ps
`include "cfm_consts.vh"

// What this block does
// - Four monitor kinds: input loss, drift, lock loss, reference oscillator loss.
// - Each defect has an active-high live flag, high only during the defect.
// - Each live flag has a sticky flag, set on defect, held until cleared.
// - Sticky capture is enabled by a configuration bit.
// - Each alarm pin shows the OR of a selected set of sticky flags.
// - Dedicated pins carry fixed defect indications software cannot reassign.
// - A selected subset of sticky flags drives the active-low interrupt pin.
// - Live and sticky states are readable and also appear on pins.
// - Input monitors watch the prescaler-divided clocks, not the raw ones.
// - Each of the four inputs is checked independently for missing edges.
// - Loss asserts once a programmable count of consecutive edges is missing.
// - Recovery means edges back with fewer missing than the recovery count.
// - Loss clears only after recovery holds unbroken for 2ms, 100ms, 200ms or 1s.
// - Drift measures each clock's offset against a selected golden clock.
// - Lock loss compares each PLL's feedback and input clock frequencies.
// - Reference oscillator loss flags a missing external or crystal reference.
// - Loss and drift configuration is reached only on register page 1.
// - Highest address holds the page; writing a listed page code to it switches the page.
module cfm_clock_fault_monitor #(
  parameter        NUM_ALARM = 4,
  parameter        CW        = 16,
  parameter [25:0] VAL0_CYC  = `CFM_VAL0_US * `CFM_CYC_PER_US,
  parameter [25:0] VAL1_CYC  = `CFM_VAL1_US * `CFM_CYC_PER_US,
  parameter [25:0] VAL2_CYC  = `CFM_VAL2_US * `CFM_CYC_PER_US,
  parameter [25:0] VAL3_CYC  = `CFM_VAL3_US * `CFM_CYC_PER_US
) (
  // Clock and reset
  input  wire                           clk_sys,
  input  wire                           rst_b,
  // Watched clocks, all asynchronous
  input  wire [3:0]                     in_div_clk,
  input  wire                           xo_clk,
  input  wire [3:0]                     pll_fb_clk,
  input  wire [3:0]                     pll_ref_clk,
  // Page selection
  input  wire                           page_wr,
  input  wire [7:0]                     page_addr,
  input  wire [7:0]                     page_wdata,
  output reg  [7:0]                     cur_page,
  // Page-1 configuration load
  input  wire                           cfg_wr,
  input  wire [4*CW-1:0]                cfg_exp_period,
  input  wire [CW-1:0]                  cfg_xo_period,
  input  wire [7:0]                     cfg_trig_edges,
  input  wire [7:0]                     cfg_clr_edges,
  input  wire [1:0]                     cfg_val_sel,
  input  wire [2:0]                     cfg_gold_sel,
  input  wire [CW-1:0]                  cfg_gate_len,
  input  wire [4*CW-1:0]                cfg_drift_exp,
  input  wire [CW-1:0]                  cfg_drift_set,
  input  wire [CW-1:0]                  cfg_drift_clr,
  // Lock loss settings
  input  wire [CW-1:0]                  ll_win,
  input  wire [CW-1:0]                  ll_set_thr,
  input  wire [CW-1:0]                  ll_clr_thr,
  // Flag control
  input  wire                           notify_en,
  input  wire                           sticky_clr,
  input  wire [`CFM_NUM_DEF-1:0]        sticky_clr_mask,
  input  wire [`CFM_NUM_DEF-1:0]        int_mask,
  input  wire [NUM_ALARM*`CFM_NUM_DEF-1:0] alarm_sel,
  // Status and alarm outputs
  output wire [`CFM_NUM_DEF-1:0]        defect_live,
  output reg  [`CFM_NUM_DEF-1:0]        defect_sticky,
  output reg  [NUM_ALARM-1:0]           alarm_pin,
  output reg                            gpio_in_loss,
  output reg                            gpio_lock_loss,
  output reg                            interrupt_out_n
);

  localparam ND = `CFM_NUM_DEF;

  // Latched page-1 settings
  reg  [4*CW-1:0] exp_period_r;
  reg  [CW-1:0]   xo_period_r;
  reg  [7:0]      trig_r;
  reg  [7:0]      clr_r;
  reg  [1:0]      vsel_r;
  reg  [2:0]      gold_r;
  reg  [CW-1:0]   gate_len_r;
  reg  [4*CW-1:0] drift_exp_r;
  reg  [CW-1:0]   drift_set_r;
  reg  [CW-1:0]   drift_clr_r;
  reg  [25:0]     val_cyc;
  wire            cfg_take;
  wire            page_ok;

  // Monitor results
  wire [3:0]      in_edge;
  wire [3:0]      in_loss;
  wire            xo_edge;
  wire            xo_loss;
  reg  [3:0]      drift_r;
  reg  [3:0]      lock_r;
  reg             gold_edge;
  reg  [CW-1:0]   gate_cnt_r;
  wire            gate_end;
  reg  [CW-1:0]   ll_cnt_r;
  wire            ll_end;
  wire [ND-1:0]   sticky_nxt;
  wire [ND-1:0]   clr_vec;
  reg  [NUM_ALARM-1:0] alarm_nxt;
  integer         a;

  // Only the listed page codes are accepted; others leave the page alone
  assign page_ok = (page_wdata == `CFM_PAGE_MASTER) || (page_wdata == `CFM_PAGE_CLKMON) ||
                   (page_wdata == `CFM_PAGE_INPUT)  || (page_wdata == `CFM_PAGE_OUTPUT) ||
                   ((page_wdata >= `CFM_PAGE_PLLA) && (page_wdata <= `CFM_PAGE_PLLD));

  // Page register at the top address of every page
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      cur_page <= `CFM_PAGE_MASTER;
    end else if (page_wr && (page_addr == `CFM_PAGE_ADDR) && page_ok) begin
      cur_page <= page_wdata;
    end
  end

  // Loss and drift settings only load while page 1 is selected
  assign cfg_take = cfg_wr && (cur_page == `CFM_PAGE_CLKMON);

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      exp_period_r <= {4{`CFM_RST_PERIOD}};
      xo_period_r  <= `CFM_RST_PERIOD;
      trig_r       <= `CFM_RST_TRIG;
      clr_r        <= `CFM_RST_CLR;
      vsel_r       <= `CFM_RST_VSEL;
      gold_r       <= `CFM_RST_GOLD;
      gate_len_r   <= `CFM_RST_GATE;
      drift_exp_r  <= {4{`CFM_RST_DEXP}};
      drift_set_r  <= `CFM_RST_DSET;
      drift_clr_r  <= `CFM_RST_DCLR;
    end else if (cfg_take) begin
      exp_period_r <= cfg_exp_period;
      xo_period_r  <= cfg_xo_period;
      trig_r       <= cfg_trig_edges;
      clr_r        <= cfg_clr_edges;
      vsel_r       <= cfg_val_sel;
      gold_r       <= cfg_gold_sel;
      gate_len_r   <= cfg_gate_len;
      drift_exp_r  <= cfg_drift_exp;
      drift_set_r  <= cfg_drift_set;
      drift_clr_r  <= cfg_drift_clr;
    end
  end

  // Validation period choice
  always @* begin
    case (vsel_r)
      `CFM_VSEL_2MS:   val_cyc = VAL0_CYC;
      `CFM_VSEL_100MS: val_cyc = VAL1_CYC;
      `CFM_VSEL_200MS: val_cyc = VAL2_CYC;
      `CFM_VSEL_1S:    val_cyc = VAL3_CYC;
      default:         val_cyc = VAL0_CYC;
    endcase
  end

  // Input loss watchers on the divided clocks, one per input
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_in
      cfm_edge_loss #(
        .PW (CW),
        .EW (8),
        .VW (26)
      ) u_loss (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .clk_pin    (in_div_clk[i]),
        .exp_period (exp_period_r[i*CW +: CW]),
        .trig_edges (trig_r),
        .clr_edges  (clr_r),
        .val_cyc    (val_cyc),
        .edge_pls   (in_edge[i]),
        .loss       (in_loss[i])
      );
    end
  endgenerate

  // Reference oscillator watcher, same missing-edge scheme
  cfm_edge_loss #(
    .PW (CW),
    .EW (8),
    .VW (26)
  ) u_xo_loss (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .clk_pin    (xo_clk),
    .exp_period (xo_period_r),
    .trig_edges (trig_r),
    .clr_edges  (clr_r),
    .val_cyc    (val_cyc),
    .edge_pls   (xo_edge),
    .loss       (xo_loss)
  );

  // Golden clock choice; the reference oscillator is the default
  always @* begin
    case (gold_r)
      3'h0:        gold_edge = in_edge[0];
      3'h1:        gold_edge = in_edge[1];
      3'h2:        gold_edge = in_edge[2];
      3'h3:        gold_edge = in_edge[3];
      `CFM_GOLD_XO: gold_edge = xo_edge;
      default:     gold_edge = xo_edge;
    endcase
  end

  // Gate measured in golden edges, so drift is relative to that clock
  assign gate_end = gold_edge &&
                    ({1'b0, gate_cnt_r} + {{CW{1'b0}}, 1'b1} >= {1'b0, gate_len_r});

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      gate_cnt_r <= {CW{1'b0}};
    end else if (gate_end) begin
      gate_cnt_r <= {CW{1'b0}};
    end else if (gold_edge) begin
      gate_cnt_r <= gate_cnt_r + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Per-input edge count over the gate, compared with the expected count
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_drift
      reg  [CW-1:0] cnt_r;
      wire [CW-1:0] exp_c;
      wire [CW-1:0] dev;
      assign exp_c = drift_exp_r[i*CW +: CW];
      assign dev   = (cnt_r > exp_c) ? (cnt_r - exp_c) : (exp_c - cnt_r);

      always @(posedge clk_sys) begin
        if (!rst_b) begin
          cnt_r      <= {CW{1'b0}};
          drift_r[i] <= 1'b0;
        end else if (gate_end) begin
          cnt_r <= {{(CW-1){1'b0}}, in_edge[i]};
          // Separate set and clear levels give hysteresis at the threshold
          if (dev > drift_set_r) begin
            drift_r[i] <= 1'b1;
          end else if (dev <= drift_clr_r) begin
            drift_r[i] <= 1'b0;
          end
        end else if (in_edge[i] && (cnt_r != {CW{1'b1}})) begin
          cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  endgenerate

  // Lock-loss window timed by the reference clock
  assign ll_end = ({1'b0, ll_cnt_r} + {{CW{1'b0}}, 1'b1}) >= {1'b0, ll_win};

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      ll_cnt_r <= {CW{1'b0}};
    end else if (ll_end) begin
      ll_cnt_r <= {CW{1'b0}};
    end else begin
      ll_cnt_r <= ll_cnt_r + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Feedback and input edges of each PLL counted over the same window
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_lock
      reg  [2:0]    fb_s_r;
      reg  [2:0]    rf_s_r;
      reg  [1:0]    fb_l_r;
      reg  [1:0]    rf_l_r;
      reg  [CW-1:0] fb_cnt_r;
      reg  [CW-1:0] rf_cnt_r;
      wire          fb_edge;
      wire          rf_edge;
      wire [CW-1:0] ll_dev;
      assign fb_edge = fb_l_r[0] & ~fb_l_r[1];
      assign rf_edge = rf_l_r[0] & ~rf_l_r[1];
      assign ll_dev  = (fb_cnt_r > rf_cnt_r) ? (fb_cnt_r - rf_cnt_r) : (rf_cnt_r - fb_cnt_r);

      // Three-stage samplers with agreement filter
      always @(posedge clk_sys) begin
        if (!rst_b) begin
          fb_s_r <= 3'h0;
          rf_s_r <= 3'h0;
          fb_l_r <= 2'h0;
          rf_l_r <= 2'h0;
        end else begin
          fb_s_r    <= {fb_s_r[1:0], pll_fb_clk[i]};
          rf_s_r    <= {rf_s_r[1:0], pll_ref_clk[i]};
          fb_l_r[1] <= fb_l_r[0];
          rf_l_r[1] <= rf_l_r[0];
          if (fb_s_r[1] == fb_s_r[2]) begin
            fb_l_r[0] <= fb_s_r[2];
          end
          if (rf_s_r[1] == rf_s_r[2]) begin
            rf_l_r[0] <= rf_s_r[2];
          end
        end
      end

      always @(posedge clk_sys) begin
        if (!rst_b) begin
          fb_cnt_r  <= {CW{1'b0}};
          rf_cnt_r  <= {CW{1'b0}};
          lock_r[i] <= 1'b0;
        end else if (ll_end) begin
          fb_cnt_r <= {CW{1'b0}};
          rf_cnt_r <= {CW{1'b0}};
          if (ll_dev > ll_set_thr) begin
            lock_r[i] <= 1'b1;
          end else if (ll_dev <= ll_clr_thr) begin
            lock_r[i] <= 1'b0;
          end
        end else begin
          if (fb_edge && (fb_cnt_r != {CW{1'b1}})) begin
            fb_cnt_r <= fb_cnt_r + {{(CW-1){1'b0}}, 1'b1};
          end
          if (rf_edge && (rf_cnt_r != {CW{1'b1}})) begin
            rf_cnt_r <= rf_cnt_r + {{(CW-1){1'b0}}, 1'b1};
          end
        end
      end
    end
  endgenerate

  // Live defect vector, all four monitor kinds
  assign defect_live = {xo_loss, lock_r, drift_r, in_loss};

  // Set wins over a same-cycle clear so no defect is lost
  assign clr_vec    = sticky_clr ? sticky_clr_mask : {ND{1'b0}};
  assign sticky_nxt = (defect_sticky & ~clr_vec) |
                      (notify_en ? defect_live : {ND{1'b0}});

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      defect_sticky <= {ND{1'b0}};
    end else begin
      defect_sticky <= sticky_nxt;
    end
  end

  // Alarm pin terms from the selected sticky flags
  always @* begin
    alarm_nxt = {NUM_ALARM{1'b0}};
    for (a = 0; a < NUM_ALARM; a = a + 1) begin
      alarm_nxt[a] = |(defect_sticky & alarm_sel[a*ND +: ND]);
    end
  end

  // Registered pins; the dedicated ones have fixed meaning
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      alarm_pin       <= {NUM_ALARM{1'b0}};
      gpio_in_loss    <= 1'b0;
      gpio_lock_loss  <= 1'b0;
      interrupt_out_n <= 1'b1;
    end else begin
      alarm_pin       <= alarm_nxt;
      gpio_in_loss    <= |defect_live[`CFM_DEF_DRIFT_LSB-1:`CFM_DEF_LOSS_LSB];
      gpio_lock_loss  <= |defect_live[`CFM_DEF_XO_BIT-1:`CFM_DEF_LOCK_LSB];
      interrupt_out_n <= ~|(defect_sticky & int_mask);
    end
  end

endmodule

// [core/cfm_edge_loss.v]
`timescale 1ns/10ps
`include "cfm_consts.vh"

// Missing-edge watcher for one clock sampled in the reference domain
module cfm_edge_loss #(
  parameter PW = 16,
  parameter EW = 8,
  parameter VW = 26
) (
  // Clock and reset
  input  wire          clk_sys,
  input  wire          rst_b,
  // Watched clock, asynchronous to clk_sys
  input  wire          clk_pin,
  // Settings
  input  wire [PW-1:0] exp_period,
  input  wire [EW-1:0] trig_edges,
  input  wire [EW-1:0] clr_edges,
  input  wire [VW-1:0] val_cyc,
  // Results
  output reg           edge_pls,
  output reg           loss
);

  reg          s1_r;
  reg          s2_r;
  reg          s3_r;
  reg          filt_r;
  reg          filt_d_r;
  reg [PW-1:0] win_r;
  reg [EW-1:0] miss_r;
  reg [VW-1:0] val_r;
  wire         rise;
  wire         win_end;
  wire         rec_ok;

  // Three-stage sampler; level moves only when stages two and three agree
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      s1_r     <= 1'b0;
      s2_r     <= 1'b0;
      s3_r     <= 1'b0;
      filt_r   <= 1'b0;
      filt_d_r <= 1'b0;
      edge_pls <= 1'b0;
    end else begin
      s1_r     <= clk_pin;
      s2_r     <= s1_r;
      s3_r     <= s2_r;
      if (s2_r == s3_r) begin
        filt_r <= s3_r;
      end
      filt_d_r <= filt_r;
      edge_pls <= filt_r & ~filt_d_r;
    end
  end

  assign rise    = filt_r & ~filt_d_r;
  assign win_end = ({1'b0, win_r} + {{PW{1'b0}}, 1'b1}) >= {1'b0, exp_period};
  assign rec_ok  = miss_r < clr_edges;

  // One expected period timed by the reference clock without an edge counts as one missing edge
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      win_r  <= {PW{1'b0}};
      miss_r <= {EW{1'b0}};
    end else if (rise) begin
      win_r  <= {PW{1'b0}};
      miss_r <= {EW{1'b0}};
    end else if (win_end) begin
      win_r  <= {PW{1'b0}};
      if (miss_r != {EW{1'b1}}) begin
        miss_r <= miss_r + {{(EW-1){1'b0}}, 1'b1};
      end
    end else begin
      win_r  <= win_r + {{(PW-1){1'b0}}, 1'b1};
    end
  end

  // Loss sets on the trigger count, clears after an unbroken validation wait
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      loss  <= 1'b0;
      val_r <= {VW{1'b0}};
    end else if (!loss) begin
      val_r <= {VW{1'b0}};
      if (miss_r >= trig_edges) begin
        loss <= 1'b1;
      end
    end else if (!rec_ok) begin
      val_r <= {VW{1'b0}};
    end else if (val_r + {{(VW-1){1'b0}}, 1'b1} >= val_cyc) begin
      loss  <= 1'b0;
      val_r <= {VW{1'b0}};
    end else begin
      val_r <= val_r + {{(VW-1){1'b0}}, 1'b1};
    end
  end

endmodule

// [include/cfm_consts.vh]
`ifndef CFM_CONSTS_VH
`define CFM_CONSTS_VH

// System clock rate and derived cycles per microsecond
`define CFM_CLK_HZ        40000000
`define CFM_CYC_PER_US    (`CFM_CLK_HZ / 1000000)

// Validation periods in microseconds
`define CFM_VAL0_US       2000
`define CFM_VAL1_US       100000
`define CFM_VAL2_US       200000
`define CFM_VAL3_US       1000000

// Validation period select codes
`define CFM_VSEL_2MS      2'h0
`define CFM_VSEL_100MS    2'h1
`define CFM_VSEL_200MS    2'h2
`define CFM_VSEL_1S       2'h3

// Defect vector layout
`define CFM_NUM_DEF       13
`define CFM_DEF_LOSS_LSB  0
`define CFM_DEF_DRIFT_LSB 4
`define CFM_DEF_LOCK_LSB  8
`define CFM_DEF_XO_BIT    12

// Page codes and the page-select location
`define CFM_PAGE_ADDR     8'hFF
`define CFM_PAGE_MASTER   8'h00
`define CFM_PAGE_CLKMON   8'h01
`define CFM_PAGE_INPUT    8'h02
`define CFM_PAGE_OUTPUT   8'h03
`define CFM_PAGE_PLLA     8'h0A
`define CFM_PAGE_PLLD     8'h0D

// Golden reference select codes (0..3 inputs)
`define CFM_GOLD_XO       3'h4

// Reset values of the page-1 configuration
`define CFM_RST_PERIOD    16'h0040
`define CFM_RST_TRIG      8'h04
`define CFM_RST_CLR       8'h02
`define CFM_RST_VSEL      2'h0
`define CFM_RST_GOLD      3'h4
`define CFM_RST_GATE      16'h1000
`define CFM_RST_DEXP      16'h0100
`define CFM_RST_DSET      16'h0010
`define CFM_RST_DCLR      16'h0008

`endif

// [sim/cfm_checker.sv]
`timescale 1ns/10ps
`include "cfm_consts.vh"

// Port-level watcher for the clock fault monitor
module cfm_checker #(
  parameter NUM_ALARM = 4,
  parameter CW        = 16
) (
  // Clock and reset
  input wire                                clk_sys,
  input wire                                rst_b,
  // Page selection
  input wire                                page_wr,
  input wire [7:0]                          page_addr,
  input wire [7:0]                          page_wdata,
  input wire [7:0]                          cur_page,
  // Flag control
  input wire                                notify_en,
  input wire                                sticky_clr,
  input wire [`CFM_NUM_DEF-1:0]             sticky_clr_mask,
  input wire [`CFM_NUM_DEF-1:0]             int_mask,
  input wire [NUM_ALARM*`CFM_NUM_DEF-1:0]   alarm_sel,
  // Status outputs
  input wire [`CFM_NUM_DEF-1:0]             defect_live,
  input wire [`CFM_NUM_DEF-1:0]             defect_sticky,
  input wire [NUM_ALARM-1:0]                alarm_pin,
  input wire                                gpio_in_loss,
  input wire                                gpio_lock_loss,
  input wire                                interrupt_out_n
);
  // Codes the page register accepts
  function automatic logic ok_code(input logic [7:0] c);
    return (c <= 8'h03) || (c >= 8'h0A && c <= 8'h0D);
  endfunction

  // Alarm pin value from sticky flags and selections
  function automatic logic [NUM_ALARM-1:0] alm(input logic [12:0] s,
                                               input logic [NUM_ALARM*13-1:0] sel);
    for (int a = 0; a < NUM_ALARM; a++) alm[a] = |(s & sel[13*a +: 13]);
  endfunction

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // Named steps of page take and loss hold
  sequence s_page_take;
    page_wr && page_addr == 8'hFF && ok_code(page_wdata);
  endsequence
  sequence s_loss_up;
    $rose(defect_live[3:0] != 4'h0);
  endsequence

  property p_page_take;
    s_page_take |=> cur_page == $past(page_wdata);
  endproperty
  property p_page_keep;
    !(page_wr && page_addr == 8'hFF && ok_code(page_wdata)) |=> $stable(cur_page);
  endproperty
  property p_sticky_set;
    notify_en |=> (defect_sticky & $past(defect_live)) == $past(defect_live);
  endproperty
  property p_sticky_keep;
    !sticky_clr |=> (defect_sticky & $past(defect_sticky)) == $past(defect_sticky);
  endproperty
  property p_no_capture;
    !notify_en |=> (defect_sticky & ~$past(defect_sticky)) == 13'h0000;
  endproperty
  property p_clear;
    sticky_clr && !notify_en |=> (defect_sticky & $past(sticky_clr_mask)) == 13'h0000;
  endproperty
  property p_alarm;
    1'b1 |=> alarm_pin == alm($past(defect_sticky), $past(alarm_sel));
  endproperty
  property p_int;
    1'b1 |=> interrupt_out_n == !(|($past(defect_sticky) & $past(int_mask)));
  endproperty
  property p_gpio;
    1'b1 |=> gpio_in_loss == |$past(defect_live[3:0])
             && gpio_lock_loss == |$past(defect_live[11:8]);
  endproperty
  // Validation wait keeps a fresh loss up well beyond a few cycles
  property p_loss_held;
    s_loss_up |=> (defect_live[3:0] != 4'h0) [*8];
  endproperty

  a_page_take: assert property (p_page_take) else $error("page code not taken");
  a_page_keep: assert property (p_page_keep) else $error("page changed unasked");
  a_sticky_set: assert property (p_sticky_set) else $error("sticky missed live");
  a_sticky_keep: assert property (p_sticky_keep) else $error("sticky dropped");
  a_no_capture: assert property (p_no_capture) else $error("sticky set while off");
  a_clear: assert property (p_clear) else $error("sticky not cleared");
  a_alarm: assert property (p_alarm) else $error("alarm pin wrong");
  a_int: assert property (p_int) else $error("interrupt pin wrong");
  a_gpio: assert property (p_gpio) else $error("fixed pin wrong");
  a_loss_held: assert property (p_loss_held) else $error("loss cleared early");
endmodule

// [sim/cfm_clk_src.sv]
`timescale 1ns/10ps

// Far side: divided inputs, PLL clocks and reference, each can stop or retune
module cfm_clk_src (
  // Clock outputs
  output wire [3:0] in_div_clk,
  output wire       xo_clk,
  output wire [3:0] pll_fb_clk,
  output wire [3:0] pll_ref_clk
);
  wire  [12:0] ck;
  logic [12:0] run = 13'h1FFF;
  int          hp [13] = '{default: 100};

  // A stopped source rests low rather than freezing mid-level
  for (genvar g = 0; g < 13; g++) begin : g_src
    logic c = 1'b0;
    always begin
      #(hp[g]);
      c = run[g] ? ~c : 1'b0;
    end
    assign ck[g] = c;
  end

  // Channel map: inputs, feedback, PLL input, reference
  assign in_div_clk  = ck[3:0];
  assign pll_fb_clk  = ck[7:4];
  assign pll_ref_clk = ck[11:8];
  assign xo_clk      = ck[12];
endmodule

// [sim/tb.sv]
`timescale 1ns/10ps
`include "cfm_consts.vh"

// Self-checking bench for the clock fault monitor
module tb;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        page_wr = 1'b0;
  logic [7:0]  page_addr = 8'h00;
  logic [7:0]  page_wdata = 8'h00;
  logic        cfg_wr = 1'b0;
  logic [63:0] cfg_exp_period = {4{16'h0001}};
  logic [15:0] cfg_xo_period = 16'h0010;
  logic [7:0]  cfg_trig_edges = 8'h04;
  logic [7:0]  cfg_clr_edges = 8'h02;
  logic [1:0]  cfg_val_sel = 2'h0;
  logic [2:0]  cfg_gold_sel = 3'h4;
  logic [15:0] cfg_gate_len = 16'h0010;
  logic [63:0] cfg_drift_exp = {4{16'h0010}};
  logic [15:0] cfg_drift_set = 16'h0002;
  logic [15:0] cfg_drift_clr = 16'h0001;
  logic [15:0] ll_win = 16'h00A0;
  logic [15:0] ll_set_thr = 16'h0002;
  logic [15:0] ll_clr_thr = 16'h0001;
  logic        notify_en = 1'b1;
  logic        sticky_clr = 1'b0;
  logic [12:0] sticky_clr_mask = 13'h0000;
  logic [12:0] int_mask = 13'h0000;
  logic [51:0] alarm_sel = 52'h0;
  wire  [3:0]  in_div_clk, pll_fb_clk, pll_ref_clk, alarm_pin;
  wire         xo_clk, gpio_in_loss, gpio_lock_loss, interrupt_out_n;
  wire  [7:0]  cur_page;
  wire  [12:0] defect_live, defect_sticky;
  int          err_total = 0;
  int          n_compared = 0;
  int          n, k;
  logic [7:0]  codes [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0A, 8'h0B, 8'h0C, 8'h0D};
  logic [12:0] e;

  always #12.5 clk_sys = ~clk_sys;

  cfm_clk_src u_src (.in_div_clk, .xo_clk, .pll_fb_clk, .pll_ref_clk);

  // Validation periods shortened so all four codes fit the run
  cfm_clock_fault_monitor #(.VAL0_CYC(26'd40), .VAL1_CYC(26'd80), .VAL2_CYC(26'd120),
    .VAL3_CYC(26'd160)) dut (.clk_sys, .rst_b, .in_div_clk, .xo_clk, .pll_fb_clk,
    .pll_ref_clk, .page_wr, .page_addr, .page_wdata, .cur_page, .cfg_wr,
    .cfg_exp_period, .cfg_xo_period, .cfg_trig_edges, .cfg_clr_edges, .cfg_val_sel,
    .cfg_gold_sel, .cfg_gate_len, .cfg_drift_exp, .cfg_drift_set, .cfg_drift_clr,
    .ll_win, .ll_set_thr, .ll_clr_thr, .notify_en, .sticky_clr, .sticky_clr_mask,
    .int_mask, .alarm_sel, .defect_live, .defect_sticky, .alarm_pin, .gpio_in_loss,
    .gpio_lock_loss, .interrupt_out_n);

  // Expected alarm pins from expected sticky flags
  function automatic logic [3:0] f_alarm(input logic [12:0] s, input logic [51:0] sel);
    for (int a = 0; a < 4; a++) f_alarm[a] = |(s & sel[13*a +: 13]);
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("[ERR] t=%0t cycles=%h range=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic page_set(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    page_wr = 1'b1;
    page_addr = a;
    page_wdata = d;
    @(negedge clk_sys);
    page_wr = 1'b0;
  endtask

  task automatic cfg_pulse();
    @(negedge clk_sys);
    cfg_wr = 1'b1;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
  endtask

  task automatic sclr(input logic [12:0] m);
    @(negedge clk_sys);
    sticky_clr = 1'b1;
    sticky_clr_mask = m;
    @(negedge clk_sys);
    sticky_clr = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask

  // Bounded wait until the masked live flags match
  task automatic wait_live(input logic [12:0] m, input logic [12:0] x, input int mx);
    n = 0;
    while ((defect_live & m) !== x && n < mx) begin
      @(negedge clk_sys);
      n++;
    end
  endtask

  // Sticky flags and the pins they drive
  task automatic pins(input logic [12:0] s);
    chk(defect_sticky, s);
    chk(alarm_pin, f_alarm(s, alarm_sel));
    chk(interrupt_out_n, ~|(s & int_mask));
  endtask

  // Disturb one source, see exactly its defect, restore, see it go
  task automatic fault(input int ch, input int hp, input logic [12:0] x);
    u_src.hp[ch] = (hp == 0) ? 100 : hp;
    u_src.run[ch] = (hp != 0);
    wait_live(13'h1FFF, x, 900);
    chk(defect_live, x);
    u_src.hp[ch] = 100;
    u_src.run[ch] = 1'b1;
    wait_live(13'h1FFF, 13'h0000, 900);
    chk(defect_live, 13'h0000);
  endtask

  initial begin
    void'($urandom(32'hEFD93C08));
    repeat (4) @(negedge clk_sys);
    rst_b = 1'b1;
    @(negedge clk_sys);
    chk({cur_page, defect_live, defect_sticky, alarm_pin, interrupt_out_n},
        {8'h00, 13'h0000, 13'h0000, 4'h0, 1'b1});
    foreach (codes[i]) begin
      page_set(8'hFF, codes[i]);
      chk(cur_page, codes[i]);
    end
    page_set(8'hFF, 8'h05);
    chk(cur_page, 8'h0D);
    page_set(8'($urandom_range(254)), 8'h01);
    chk(cur_page, 8'h0D);
    // A one-cycle period would flag every input if taken off page 1
    page_set(8'hFF, 8'h00);
    cfg_pulse();
    repeat (100) @(negedge clk_sys);
    chk(defect_live, 13'h0000);
    cfg_exp_period = {4{16'h0010}};
    for (int v = 0; v < 4; v++) begin
      k = $urandom_range(3);
      cfg_val_sel = v[1:0];
      cfg_gold_sel = (k == v || v == 3) ? 3'h4 : 3'(v); // Last pass back on the reference
      page_set(8'hFF, 8'h01);
      cfg_pulse();
      notify_en = (v != 1);
      alarm_sel = 52'({$urandom, $urandom});
      int_mask = 13'($urandom);
      @(negedge clk_sys);
      u_src.run[k] = 1'b0;
      wait_live(13'h1 << k, 13'h1 << k, 200);
      chk_rng(n, 50, 80);
      e = (13'h1 << k) | (13'h10 << k);
      wait_live(13'h1FFF, e, 600);
      chk(defect_live, e);
      u_src.run[k] = 1'b1;
      wait_live(13'h1 << k, 13'h0000, 400);
      chk_rng(n, 40 * (v + 1), 40 * (v + 1) + 30);
      wait_live(13'h1FFF, 13'h0000, 600);
      pins(notify_en ? e : 13'h0000);
      sclr(13'h0000);
      pins(notify_en ? e : 13'h0000);
      sclr(13'h1FFF);
      pins(13'h0000);
    end
    k = $urandom_range(3);
    fault(k, 80, 13'h10 << k);
    k = $urandom_range(3);
    fault(4 + k, 80, 13'h100 << k);
    fault(12, 0, 13'h1000);
    final_report();
  end

  // Watchdog sized well past the expected run of at most about 13000 cycles
  initial begin
    #2000000;
    err_total++;
    final_report();
  end

  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
endmodule

bind cfm_clock_fault_monitor cfm_checker #(.NUM_ALARM(NUM_ALARM), .CW(CW)) u_chk (
  .clk_sys, .rst_b, .page_wr, .page_addr, .page_wdata, .cur_page, .notify_en,
  .sticky_clr, .sticky_clr_mask, .int_mask, .alarm_sel, .defect_live, .defect_sticky,
  .alarm_pin, .gpio_in_loss, .gpio_lock_loss, .interrupt_out_n);
